// [core/timer8_consts.svh]
`ifndef TIMER8_CONSTS_SVH
`define TIMER8_CONSTS_SVH

// Register byte offsets
`define ADDR_CTRL_A      8'h00
`define ADDR_CTRL_B      8'h04
`define ADDR_COUNT       8'h08
`define ADDR_COMPARE     8'h0c
`define ADDR_FLAGS       8'h10
`define ADDR_MASK        8'h14
`define ADDR_PORT        8'h18

// Field positions
`define CTRL_A_MODE_LO   0
`define CTRL_A_COM_LO    4
`define CTRL_A_FORCE     7
`define FLAG_OVF         0
`define FLAG_CMP         1
`define PORT_DATA        0
`define PORT_DIR         1

// Waveform modes
`define MODE_NORMAL      2'h0
`define MODE_PC_PWM      2'h1
`define MODE_CLEAR_MATCH 2'h2
`define MODE_FAST_PWM    2'h3

// Counter extremes and reset values
`define COUNT_MAX        8'hff
`define COUNT_BOTTOM     8'h00
`define RESET_BYTE       8'h00

`endif

// [core/timer8_core.sv]
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`include "timer8_consts.svh"

module timer8_core (
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // Prescaler tap, one-cycle pulses
    input  wire logic        timer_tick_in,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Interrupt request and service
    input  wire logic        overflow_irq_ack,
    input  wire logic        compare_irq_ack,
    output logic             overflow_irq_req,
    output logic             compare_irq_req,
    // Compare output pin
    output logic             compare_pin_out,
    output logic             compare_pin_direction
);
    import timer8_pkg::*;

    timer8_pkg::timer_state_t st;
    timer8_pkg::timer_state_t next_st;

    logic tick;
    logic wr;
    logic wr_cnt;
    logic match;
    logic pwm;
    logic cmp_set;
    logic ovf_set;

    // Output state on a match, shared by real and forced matches
    function automatic logic oc_next(input logic [1:0] mode,
                                     input logic [1:0] com,
                                     input logic       down,
                                     input logic       oc);
        logic pc;
        pc = (mode == `MODE_PC_PWM);
        case (com)
            2'h1:    oc_next = pc ? oc : ~oc;
            2'h2:    oc_next = pc && down;
            2'h3:    oc_next = !(pc && down);
            default: oc_next = oc;
        endcase
    endfunction

    // Register read view of a state copy
    function automatic logic [31:0] read_mux(input logic [7:0] a,
                                             input timer_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `ADDR_CTRL_A: v = {2'h0, s.com, 2'h0, s.mode};
            `ADDR_CTRL_B: v = {5'h00, s.cs};
            `ADDR_COUNT:  v = s.cnt;
            `ADDR_COMPARE: begin
                if (s.mode[0])
                    v = s.ocr_buf;
                else
                    v = s.ocr_act;
            end
            `ADDR_FLAGS:  v = {6'h00, s.cmf, s.ovf};
            `ADDR_MASK:   v = {6'h00, s.cmp_en, s.ovf_en};
            `ADDR_PORT:   v = {6'h00, s.pin_dir, s.port_bit};
            default:      v = 8'h00;
        endcase
        read_mux = {24'h000000, v};
    endfunction

    // Decoded events of the current cycle
    assign tick    = (st.cs != 3'h0) && timer_tick_in;
    assign wr      = st.dp_valid && st.dp_write;
    assign wr_cnt  = wr && (st.dp_addr == `ADDR_COUNT);
    assign pwm     = st.mode[0]; // modes 1 and 3 are the PWM ones
    assign match   = (st.cnt == st.ocr_act);
    assign cmp_set = tick && match && !st.block;
    assign ovf_set = tick && !wr_cnt && (
        ((st.mode == `MODE_NORMAL) && (st.cnt == `COUNT_MAX)) ||
        ((st.mode == `MODE_CLEAR_MATCH) && (st.cnt == `COUNT_MAX)) ||
        ((st.mode == `MODE_FAST_PWM) && (st.cnt == 8'hfe)) ||
        ((st.mode == `MODE_PC_PWM) && st.down &&
         (st.cnt == `COUNT_BOTTOM)));

    // Next state: clears first, then hardware events, then software writes
    always_comb begin
        next_st = st;

        // Service and write-one clears; a same-cycle set below wins
        if (overflow_irq_ack)
            next_st.ovf = 1'b0;
        if (compare_irq_ack)
            next_st.cmf = 1'b0;
        if (wr && (st.dp_addr == `ADDR_FLAGS)) begin
            if (hwdata[`FLAG_OVF])
                next_st.ovf = 1'b0;
            if (hwdata[`FLAG_CMP])
                next_st.cmf = 1'b0;
        end

        // Counter sequence per waveform mode
        if (tick && !wr_cnt) begin
            next_st.block = 1'b0;
            case (st.mode)
                `MODE_NORMAL: begin
                    next_st.cnt = st.cnt + 8'h01;
                end
                `MODE_CLEAR_MATCH: begin
                    if (match)
                        next_st.cnt = `COUNT_BOTTOM;
                    else
                        next_st.cnt = st.cnt + 8'h01;
                end
                `MODE_FAST_PWM: begin
                    if (st.cnt == `COUNT_MAX) begin
                        next_st.cnt     = `COUNT_BOTTOM;
                        next_st.ocr_act = st.ocr_buf;
                    end else begin
                        next_st.cnt = st.cnt + 8'h01;
                    end
                end
                `MODE_PC_PWM: begin
                    if (!st.down && (st.cnt == `COUNT_MAX)) begin
                        next_st.down    = 1'b1;
                        next_st.cnt     = st.cnt - 8'h01;
                        next_st.ocr_act = st.ocr_buf;
                    end else if (st.down && (st.cnt == `COUNT_BOTTOM)) begin
                        next_st.down = 1'b0;
                        next_st.cnt  = st.cnt + 8'h01;
                    end else if (st.down) begin
                        next_st.cnt = st.cnt - 8'h01;
                    end else begin
                        next_st.cnt = st.cnt + 8'h01;
                    end
                end
                default: begin
                    next_st.cnt = st.cnt;
                end
            endcase
        end
        if (ovf_set)
            next_st.ovf = 1'b1;

        // Match action; action bits are taken live, never buffered
        if (cmp_set) begin
            next_st.cmf = 1'b1;
            next_st.oc  = oc_next(st.mode, st.com, st.down, st.oc);
        end
        // Fast PWM restores the output at the wrap to bottom, for actions 2 and 3 only
        if (tick && !wr_cnt && (st.mode == `MODE_FAST_PWM) &&
            (st.cnt == `COUNT_MAX)) begin
            if (st.com == 2'h2)
                next_st.oc = 1'b1;
            else if (st.com == 2'h3)
                next_st.oc = 1'b0;
        end

        // Software writes in the data phase
        if (wr) begin
            case (st.dp_addr)
                `ADDR_CTRL_A: begin
                    // Mode change leaves the output state alone
                    next_st.mode = hwdata[`CTRL_A_MODE_LO +: 2];
                    next_st.com  = hwdata[`CTRL_A_COM_LO +: 2];
                    if (hwdata[`CTRL_A_FORCE] && !pwm)
                        next_st.oc = oc_next(st.mode, st.com, st.down,
                                             st.oc);
                end
                `ADDR_CTRL_B: next_st.cs = hwdata[2:0];
                `ADDR_COUNT: begin
                    next_st.cnt   = hwdata[7:0];
                    next_st.block = 1'b1;
                end
                `ADDR_COMPARE: begin
                    next_st.ocr_buf = hwdata[7:0];
                    if (!pwm)
                        next_st.ocr_act = hwdata[7:0];
                end
                `ADDR_MASK: begin
                    next_st.ovf_en = hwdata[`FLAG_OVF];
                    next_st.cmp_en = hwdata[`FLAG_CMP];
                end
                `ADDR_PORT: begin
                    next_st.port_bit = hwdata[`PORT_DATA];
                    next_st.pin_dir  = hwdata[`PORT_DIR];
                end
                default: begin
                    next_st.cs = st.cs;
                end
            endcase
        end

        // Address phase capture; read data from the updated view
        if (hready) begin
            next_st.dp_valid = hsel && htrans[1];
            next_st.dp_write = hwrite;
            next_st.dp_addr  = haddr[7:0];
            if (hsel && htrans[1] && !hwrite)
                next_st.rdata = read_mux(haddr[7:0], next_st);
        end
        next_st.ready = 1'b1;
        next_st.resp  = 1'b0;

        // Registered outputs
        next_st.ovf_req = next_st.ovf && next_st.ovf_en;
        next_st.cmp_req = next_st.cmf && next_st.cmp_en;
        next_st.pin_out = (next_st.com != 2'h0) ? next_st.oc
                                                : next_st.port_bit;
        next_st.pin_oe  = next_st.pin_dir;
    end

    // State register; enable low freezes everything including the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st       <= '0;
            st.ready <= 1'b1;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign hrdata                = st.rdata;
    assign hreadyout             = st.ready;
    assign hresp                 = st.resp;
    assign overflow_irq_req      = st.ovf_req;
    assign compare_irq_req       = st.cmp_req;
    assign compare_pin_out       = st.pin_out;
    assign compare_pin_direction = st.pin_oe;

    // Checks on the core behaviour
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_STOPPED_HOLDS: assert property (
        clk_en && (st.cs == 3'h0) && !wr_cnt |=> $stable(st.cnt))
        else $error("count moved with no clock source");

    AST_WRITE_WINS: assert property (
        clk_en && wr_cnt |=> st.cnt == $past(hwdata[7:0]))
        else $error("software count write lost");

    AST_NORMAL_UP: assert property (
        clk_en && tick && !wr_cnt && (st.mode == `MODE_NORMAL)
        |=> st.cnt == $past(st.cnt) + 8'h01)
        else $error("normal mode did not increment");

    AST_OVF_AT_ZERO: assert property (
        clk_en && tick && !wr_cnt && (st.mode == `MODE_NORMAL) &&
        (st.cnt == `COUNT_MAX) |=> st.ovf && (st.cnt == `COUNT_BOTTOM))
        else $error("overflow flag missed at wrap");

    AST_MATCH_FLAG: assert property (
        clk_en && tick && match && !st.block |=> st.cmf)
        else $error("match flag not set");

    AST_BLOCKED: assert property (
        clk_en && wr_cnt ##1 clk_en && tick && !st.cmf
        |=> !st.cmf)
        else $error("match not blocked after count write");

    AST_W1C: assert property (
        clk_en && wr && (st.dp_addr == `ADDR_FLAGS) && hwdata[`FLAG_CMP]
        && !cmp_set |=> !st.cmf)
        else $error("write one did not clear match flag");

    AST_COM_ZERO_HOLD: assert property (
        clk_en && (st.com == 2'h0) && !wr |=> $stable(st.oc))
        else $error("output state moved with action zero");

    AST_PIN_SOURCE: assert property (
        compare_pin_out == ((st.com != 2'h0) ? st.oc : st.port_bit)
        && compare_pin_direction == st.pin_dir)
        else $error("pin source wrong");

    AST_IRQ_REQ: assert property (
        compare_irq_req == (st.cmf && st.cmp_en))
        else $error("compare request disagrees with flag");

    // Counting sequences of the other waveform modes
    AST_CLEAR_MATCH: assert property (
        clk_en && tick && !wr_cnt && (st.mode == `MODE_CLEAR_MATCH) &&
        match |=> st.cnt == `COUNT_BOTTOM)
        else $error("clear-on-match mode did not clear");

    AST_FAST_WRAP: assert property (
        clk_en && tick && !wr_cnt && (st.mode == `MODE_FAST_PWM) &&
        (st.cnt == `COUNT_MAX)
        |=> (st.cnt == `COUNT_BOTTOM) && (st.ocr_act == $past(st.ocr_buf)))
        else $error("fast mode wrap or compare load wrong");

    AST_PC_TURN: assert property (
        clk_en && tick && !wr_cnt && (st.mode == `MODE_PC_PWM) &&
        !st.down && (st.cnt == `COUNT_MAX)
        |=> st.down && (st.cnt == 8'hfe))
        else $error("phase-correct mode did not turn at top");

    // Compare value routing; a late buffer copy would glitch the output
    AST_UNBUFFERED: assert property (
        clk_en && wr && (st.dp_addr == `ADDR_COMPARE) && !pwm
        |=> st.ocr_act == $past(hwdata[7:0]))
        else $error("non-PWM compare write not direct");

    AST_BUFFERED_WRITE: assert property (
        clk_en && wr && (st.dp_addr == `ADDR_COMPARE) && pwm
        |=> st.ocr_buf == $past(hwdata[7:0]))
        else $error("PWM compare write missed the buffer");

    // Force strobe and mode changes
    AST_FORCE_NO_FLAG: assert property (
        clk_en && wr && (st.dp_addr == `ADDR_CTRL_A) &&
        hwdata[`CTRL_A_FORCE] && !cmp_set && !st.cmf |=> !st.cmf)
        else $error("force strobe set the match flag");

    AST_MODE_KEEPS_OC: assert property (
        clk_en && wr && (st.dp_addr == `ADDR_CTRL_A) &&
        !hwdata[`CTRL_A_FORCE] && !tick |=> $stable(st.oc))
        else $error("mode change moved the output state");

    // Flag clears; a same-cycle set is allowed to win
    AST_ACK_OVF: assert property (
        clk_en && overflow_irq_ack && !ovf_set |=> !st.ovf)
        else $error("overflow service did not clear flag");

    AST_ACK_CMF: assert property (
        clk_en && compare_irq_ack && !cmp_set |=> !st.cmf)
        else $error("compare service did not clear flag");

    AST_W1C_OVF: assert property (
        clk_en && wr && (st.dp_addr == `ADDR_FLAGS) && hwdata[`FLAG_OVF]
        && !ovf_set |=> !st.ovf)
        else $error("write one did not clear overflow flag");

    AST_W0_KEEPS: assert property (
        clk_en && wr && (st.dp_addr == `ADDR_FLAGS) &&
        !hwdata[`FLAG_CMP] && st.cmf && !compare_irq_ack |=> st.cmf)
        else $error("write zero cleared the match flag");

    AST_CMF_NEEDS_TICK: assert property (
        clk_en && !tick && !st.cmf |=> !st.cmf)
        else $error("match flag set without a tick");

    // Bus answers at once and always OKAY
    AST_BUS_OKAY: assert property (
        hreadyout && !hresp)
        else $error("bus not ready or not okay");

endmodule // timer8_core

// [core/timer8_pkg.sv]
package timer8_pkg;
    // Whole register state of the timer core
    typedef struct packed {
        logic [7:0]  cnt;
        logic [7:0]  ocr_act;
        logic [7:0]  ocr_buf;
        logic        down;
        logic [1:0]  mode;
        logic [1:0]  com;
        logic [2:0]  cs;
        logic        ovf;
        logic        cmf;
        logic        ovf_en;
        logic        cmp_en;
        logic        port_bit;
        logic        pin_dir;
        logic        block;
        logic        oc;
        logic        dp_valid;
        logic        dp_write;
        logic [7:0]  dp_addr;
        logic [31:0] rdata;
        logic        ready;
        logic        resp;
        logic        ovf_req;
        logic        cmp_req;
        logic        pin_out;
        logic        pin_oe;
    } timer_state_t;
endpackage

// [tb/test_timer8_core.sv]
`timescale 1ns/100ps
`include "timer8_consts.svh"

module test_timer8_core;
    // Clock, reset and drive
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        timer_tick_in = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        overflow_irq_ack = 1'b0;
    logic        compare_irq_ack = 1'b0;
    // Observed outputs
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        overflow_irq_req;
    logic        compare_irq_req;
    logic        compare_pin_out;
    logic        compare_pin_direction;
    // Tally
    int          miscompares = 0;
    int          n_checks = 0;

    // Single slave, so its ready is the bus ready
    timer8_core u_timer8_core (
        .hclk                  (hclk),
        .hresetn               (hresetn),
        .clk_en                (1'b1),
        .timer_tick_in         (timer_tick_in),
        .hsel                  (1'b1),
        .haddr                 (haddr),
        .htrans                (htrans),
        .hwrite                (hwrite),
        .hsize                 (3'h2),
        .hwdata                (hwdata),
        .hready                (hreadyout),
        .hrdata                (hrdata),
        .hreadyout             (hreadyout),
        .hresp                 (hresp),
        .overflow_irq_ack      (overflow_irq_ack),
        .compare_irq_ack       (compare_irq_ack),
        .overflow_irq_req      (overflow_irq_req),
        .compare_irq_req       (compare_irq_req),
        .compare_pin_out       (compare_pin_out),
        .compare_pin_direction (compare_pin_direction)
    );

    // 25 MHz clock
    always #20 hclk = ~hclk;

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // Ready sampled mid-cycle, on the falling edge, since it is registered
    task automatic wait_rdy(output logic [31:0] r);
        logic ok;
        int   k;
        k = 0;
        do begin
            @(negedge hclk);
            ok = hreadyout;
            r = hrdata;
            @(posedge hclk);
            k++;
        end while (ok !== 1'b1 && k < 50);
        if (k >= 50) begin
            miscompares++;
            test_done();
        end
    endtask

    // One AHB single transfer; tk raises a tick with the data phase
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic tk,
                       output logic [31:0] r);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy(r);
        htrans        <= 2'h0;
        hwdata        <= d;
        timer_tick_in <= tk;
        wait_rdy(r);
        timer_tick_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, 1'b0, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, 1'b0, r);
        check(r, exp);
    endtask

    // n timer ticks, each followed by one quiet cycle
    task automatic tick(input int n);
        repeat (n) begin
            timer_tick_in <= 1'b1;
            @(posedge hclk);
            timer_tick_in <= 1'b0;
            @(posedge hclk);
        end
    endtask

    // Look at the live output mid-cycle, well clear of its launching edge
    task automatic see(ref logic v, input logic e);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        check({31'h0, v}, {31'h0, e});
        @(posedge hclk);
    endtask

    task automatic fin(input string s);
        $display("test %s done", s);
    endtask

    initial begin
        logic [31:0] r;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset state and an unmapped slot
        rd(`ADDR_CTRL_A, 32'h0);
        rd(`ADDR_COUNT, 32'h0);
        rd(`ADDR_FLAGS, 32'h0);
        rd(8'h1c, 32'h0);
        see(hresp, 1'b0);
        see(compare_pin_direction, 1'b0);
        fin("reset");
        // No clock source: count holds
        wr(`ADDR_COUNT, 32'h05);
        tick(1);
        rd(`ADDR_COUNT, 32'h05);
        fin("stopped");
        // Normal mode wrap and overflow
        wr(`ADDR_CTRL_B, 32'h1);
        wr(`ADDR_MASK, 32'h1);
        wr(`ADDR_COUNT, 32'hfe);
        tick(1);
        rd(`ADDR_COUNT, 32'hff);
        rd(`ADDR_FLAGS, 32'h0);
        tick(1);
        rd(`ADDR_COUNT, 32'h00);
        rd(`ADDR_FLAGS, 32'h1);
        see(overflow_irq_req, 1'b1);
        overflow_irq_ack <= 1'b1;
        @(posedge hclk);
        overflow_irq_ack <= 1'b0;
        see(overflow_irq_req, 1'b0);
        rd(`ADDR_FLAGS, 32'h0);
        fin("overflow");
        // Compare match, blocking, flag clearing
        wr(`ADDR_COMPARE, 32'h10);
        wr(`ADDR_MASK, 32'h3);
        wr(`ADDR_COUNT, 32'h10);
        tick(1);
        rd(`ADDR_COUNT, 32'h11);
        rd(`ADDR_FLAGS, 32'h0);
        wr(`ADDR_COUNT, 32'h0f);
        tick(2);
        rd(`ADDR_FLAGS, 32'h2);
        see(compare_irq_req, 1'b1);
        wr(`ADDR_FLAGS, 32'h0);
        rd(`ADDR_FLAGS, 32'h2);
        wr(`ADDR_FLAGS, 32'h2);
        rd(`ADDR_FLAGS, 32'h0);
        see(compare_irq_req, 1'b0);
        wr(`ADDR_COUNT, 32'h0f);
        tick(2);
        compare_irq_ack <= 1'b1;
        @(posedge hclk);
        compare_irq_ack <= 1'b0;
        rd(`ADDR_FLAGS, 32'h0);
        fin("compare");
        // Write beats a same-cycle tick; clear-on-match mode
        bus(1'b1, `ADDR_COUNT, 32'h80, 1'b1, r);
        rd(`ADDR_COUNT, 32'h80);
        wr(`ADDR_CTRL_A, 32'h02);
        wr(`ADDR_COUNT, 32'h0f);
        tick(2);
        rd(`ADDR_COUNT, 32'h00);
        wr(`ADDR_FLAGS, 32'h3);
        fin("priority");
        // Output state, force strobe, pin override
        wr(`ADDR_CTRL_A, 32'h10);
        see(compare_pin_out, 1'b0);
        wr(`ADDR_CTRL_A, 32'h90);
        see(compare_pin_out, 1'b1);
        rd(`ADDR_FLAGS, 32'h0);
        rd(`ADDR_COUNT, 32'h00);
        wr(`ADDR_PORT, 32'h2);
        see(compare_pin_direction, 1'b1);
        wr(`ADDR_CTRL_A, 32'h12);
        see(compare_pin_out, 1'b1);
        rd(`ADDR_CTRL_A, 32'h12);
        wr(`ADDR_CTRL_A, 32'h02);
        see(compare_pin_out, 1'b0);
        wr(`ADDR_COUNT, 32'h0f);
        tick(2);
        wr(`ADDR_CTRL_A, 32'h12);
        see(compare_pin_out, 1'b1);
        wr(`ADDR_COUNT, 32'h0f);
        tick(2);
        see(compare_pin_out, 1'b0);
        fin("output");
        // Fast PWM double buffering
        wr(`ADDR_FLAGS, 32'h3);
        wr(`ADDR_CTRL_A, 32'h03);
        wr(`ADDR_COMPARE, 32'h40);
        rd(`ADDR_COMPARE, 32'h40);
        wr(`ADDR_COUNT, 32'h0f);
        tick(2);
        rd(`ADDR_FLAGS, 32'h2);
        wr(`ADDR_COUNT, 32'hff);
        tick(1);
        wr(`ADDR_FLAGS, 32'h3);
        wr(`ADDR_COUNT, 32'h3f);
        tick(2);
        rd(`ADDR_FLAGS, 32'h2);
        fin("buffer");
        // Phase-correct turns at the top
        wr(`ADDR_CTRL_A, 32'h01);
        wr(`ADDR_COUNT, 32'hfe);
        tick(1);
        rd(`ADDR_COUNT, 32'hff);
        tick(1);
        rd(`ADDR_COUNT, 32'hfe);
        fin("updown");
        test_done();
    end
endmodule // test_timer8_core
